// ### drive_io_consts.svh
// Offsets, field positions, reset values and timing counts of the I/O allocation block.
`ifndef DRIVE_IO_CONSTS_SVH
`define DRIVE_IO_CONSTS_SVH

`define CLK_PERIOD_NS 100
`define CTRL_PERIOD_NS 1600
`define CTRL_CYCLES ((`CTRL_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define INPUT_MAP_A_OFS 8'h00
`define INPUT_MAP_B_OFS 8'h04
`define OPTION_INPUT_MAP_OFS 8'h08
`define OUTPUT_MAP_A_OFS 8'h0C
`define OUTPUT_MAP_B_OFS 8'h10
`define OUTPUT_MAP_C_OFS 8'h14
`define OUTPUT_POLARITY_CTL_OFS 8'h18
`define INPUT_STATE_OFS 8'h1C
`define OUTPUT_STATE_OFS 8'h20
`define MAP_REG_COUNT 7
`define OUT_MAP_FIRST 3
`define POLARITY_IDX 6
`define POLARITY_MASK 16'h0007

`define INPUT_MAP_A_RST 16'h1000
`define INPUT_MAP_B_RST 16'h8802
`define OPTION_INPUT_MAP_RST 16'h6543
`define OUTPUT_MAP_A_RST 16'h0000
`define OUTPUT_MAP_B_RST 16'h0100
`define OUTPUT_MAP_C_RST 16'h0000
`define OUTPUT_POLARITY_RST 16'h0000

`define FWD_TRAVEL_DIGIT 2'h3
`define REV_TRAVEL_DIGIT 2'h0
`define FWD_CLAMP_DIGIT 2'h2
`define REV_CLAMP_DIGIT 2'h3

`define CODE_LAST_DEFAULT 4'h6
`define CODE_ALWAYS_ON 4'h7
`define CODE_ALWAYS_OFF 4'h8
`define CODE_FIRST_INVERTED 4'h9
`define CODE_FIRST_WIDE_CIRCUIT 3'h4
`define OUT_CODE_LAST 4'h3

`define INPUT_CIRCUITS 7
`define OUTPUT_CIRCUITS 3
`define OUTPUT_FUNCS 9
`define HSIZE_WORD 3'h2

`endif

// ### drive_io_pkg.sv
// Types shared by the I/O allocation block and its users.
package drive_io_pkg;

    typedef struct packed {
        logic option_in_6;
        logic option_in_5;
        logic option_in_4;
        logic option_in_3;
        logic rev_force_clamp_in;
        logic fwd_force_clamp_in;
        logic rev_travel_block;
        logic fwd_travel_block;
    } input_func_type;

    typedef struct packed {
        logic near_zone;
        logic warning;
        logic brake_release_out;
        logic speed_limited;
        logic force_limited;
        logic servo_ready;
        logic motion_detected;
        logic speed_match;
        logic position_reached;
    } output_func_type;

    typedef struct packed {
        logic [7:0] addr;
        logic write;
        logic active;
    } bus_req_type;

endpackage : drive_io_pkg

// ### level_sync.sv
// Two-stage synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
    parameter int WIDTH = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_reg;

    // The first stage feeds only the second stage, so no logic sees a metastable level.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage_reg <= '0;
            sync_out <= '0;
        end else begin
            stage_reg <= async_in;
            sync_out <= stage_reg;
        end
    end

endmodule : level_sync

`default_nettype wire

// ### drive_io_signal_allocation.sv
// Allocation of drive sequence functions to physical I/O circuits, with AHB-Lite registers.
//
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "drive_io_consts.svh"

// Behaviour
// - Codes 0-6 default sense, 9-F inverted
// - Code 7 forces on, code 8 off
// - Digit fields per function as assigned
// - Shared input circuit drives all its functions
// - Undetectable allocation reads as not asserted
// - Output codes 1-3 pick circuit, 0 unused
// - Shared output circuit carries OR of functions
// - Per-circuit polarity bit, reset no inversion
// - Alarm off on error; brake follows output
module drive_io_signal_allocation #(
    parameter int CTRL_CYCLES = `CTRL_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [`INPUT_CIRCUITS-1:0] circuit_in,
    input wire logic safety_block_in_1,
    input wire logic safety_block_in_2,
    input wire drive_io_pkg::output_func_type out_func,
    input wire logic drive_error,
    output drive_io_pkg::input_func_type in_func,
    output logic base_block,
    output logic [`OUTPUT_CIRCUITS-1:0] out_circuit,
    output logic alarm_out
);

    localparam int CW = (CTRL_CYCLES > 1) ? $clog2(CTRL_CYCLES) : 1;
    localparam logic [CW-1:0] TICK_LAST = CW'(CTRL_CYCLES - 1);

    logic [`INPUT_CIRCUITS+1:0] sync_level;
    logic [`INPUT_CIRCUITS-1:0] circuit_level;
    logic safety_1;
    logic safety_2;
    logic [CW-1:0] tick_count_reg;
    logic ctrl_tick;
    drive_io_pkg::bus_req_type pend_reg;
    logic [15:0] map_reg [`MAP_REG_COUNT];
    logic [15:0] map_next [`MAP_REG_COUNT];
    logic wr_hit;
    logic [2:0] wr_idx;
    logic [31:0] hrdata_reg;
    logic rd_take;
    logic [31:0] rd_word;
    logic [31:0] input_state;
    logic [31:0] output_state;
    drive_io_pkg::input_func_type in_func_next;
    logic [`OUTPUT_CIRCUITS-1:0] circuit_next;
    logic [`OUTPUT_FUNCS-1:0] out_vec;

    function automatic logic [15:0] reset_value(input int idx);
        case (idx)
            0: reset_value = `INPUT_MAP_A_RST;
            1: reset_value = `INPUT_MAP_B_RST;
            2: reset_value = `OPTION_INPUT_MAP_RST;
            3: reset_value = `OUTPUT_MAP_A_RST;
            4: reset_value = `OUTPUT_MAP_B_RST;
            5: reset_value = `OUTPUT_MAP_C_RST;
            default: reset_value = `OUTPUT_POLARITY_RST;
        endcase
    endfunction : reset_value

    function automatic logic [3:0] digit_of(input logic [15:0] value, input logic [1:0] pos);
        digit_of = value[{pos, 2'b00} +: 4];
    endfunction : digit_of

    // Active-on is the default sense: overtravel inputs assert when their circuit is off,
    // so a broken wire stops motion; the others assert when their circuit is on.
    // Narrow functions may use only the upper three circuits.
    function automatic logic pick_input(
        input logic [3:0] code,
        input logic [`INPUT_CIRCUITS-1:0] level,
        input logic active_on,
        input logic narrow
    );
        logic [3:0] idx;
        logic invert;
        idx = 4'h0;
        invert = 1'b0;
        pick_input = 1'b0;
        if (code == `CODE_ALWAYS_ON) begin
            pick_input = 1'b1;
        end else if (code == `CODE_ALWAYS_OFF) begin
            pick_input = 1'b0;
        end else begin
            if (code <= `CODE_LAST_DEFAULT) begin
                idx = code;
            end else begin
                // Inverted codes reuse the circuit order of the default codes, offset by nine.
                idx = code - `CODE_FIRST_INVERTED;
                invert = 1'b1;
            end
            if (narrow && idx[2:0] < `CODE_FIRST_WIDE_CIRCUIT) begin
                pick_input = 1'b0;
            end else begin
                pick_input = (level[idx[2:0]] == active_on) ^ invert;
            end
        end
    endfunction : pick_input

    function automatic logic [1:0] out_sel(input logic [3:0] code);
        out_sel = code[1:0] - 2'h1;
    endfunction : out_sel

    // Codes 4 to F route nowhere, the same as code 0.
    function automatic logic out_used(input logic [3:0] code);
        out_used = (code != 4'h0) && (code <= `OUT_CODE_LAST);
    endfunction : out_used

    // Pins and safety channels come from outside the clock domain and pass two stages here.
    level_sync #(
        .WIDTH(`INPUT_CIRCUITS + 2)
    ) pin_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in({safety_block_in_2, safety_block_in_1, circuit_in}),
        .sync_out(sync_level)
    );

    // The safety channels ride in the top two bits of the synchronised word.
    assign circuit_level = sync_level[`INPUT_CIRCUITS-1:0];
    assign safety_1 = sync_level[`INPUT_CIRCUITS];
    assign safety_2 = sync_level[`INPUT_CIRCUITS+1];

    // Control-cycle timebase; every routing decision is taken on this enable.
    // A longer period eases timing of the routing logic but delays every pin change.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_count_reg <= '0;
        end else if (tick_count_reg == TICK_LAST) begin
            tick_count_reg <= '0;
        end else begin
            tick_count_reg <= tick_count_reg + CW'(1);
        end
    end

    assign ctrl_tick = (tick_count_reg == TICK_LAST);

    // Bus address phase is captured whenever the bus is ready; zero wait states.
    // Non-word sizes never arm a transfer, so they complete as OKAY and change nothing.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_reg <= '0;
        end else if (hready) begin
            pend_reg.addr <= haddr[7:0];
            pend_reg.write <= hwrite;
            pend_reg.active <= hsel && htrans[1] && (hsize == `HSIZE_WORD);
        end
    end

    // A write is armed in the address phase and committed in the data phase, when hwdata
    // stands; misaligned, unmapped and read-only offsets never commit it.
    assign wr_idx = pend_reg.addr[4:2];
    assign wr_hit = pend_reg.active && pend_reg.write && (pend_reg.addr[1:0] == 2'h0)
                    && (pend_reg.addr[7:5] == 3'h0) && (wr_idx < 3'(`MAP_REG_COUNT));

    // Only the three polarity bits exist; the rest of that word reads back as zero.
    always_comb begin
        for (int i = 0; i < `MAP_REG_COUNT; i++) begin
            map_next[i] = map_reg[i];
        end
        if (wr_hit) begin
            if (wr_idx == 3'(`POLARITY_IDX)) begin
                map_next[wr_idx] = hwdata[15:0] & `POLARITY_MASK;
            end else begin
                map_next[wr_idx] = hwdata[15:0];
            end
        end
    end

    // The map registers reset to the factory allocation; polarity starts uninverted.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < `MAP_REG_COUNT; i++) begin
                map_reg[i] <= reset_value(i);
            end
        end else begin
            for (int i = 0; i < `MAP_REG_COUNT; i++) begin
                map_reg[i] <= map_next[i];
            end
        end
    end

    assign rd_take = hready && hsel && htrans[1] && !hwrite && (hsize == `HSIZE_WORD);
    assign input_state = {15'h0000, safety_2, safety_1, circuit_level, in_func};
    assign output_state = {26'h0000000, base_block, alarm_out, 1'b0, out_circuit};

    // Reads see map_next, so a read straight after a write returns the new value.
    always_comb begin
        case (haddr[7:0])
            `INPUT_MAP_A_OFS: rd_word = {16'h0000, map_next[0]};
            `INPUT_MAP_B_OFS: rd_word = {16'h0000, map_next[1]};
            `OPTION_INPUT_MAP_OFS: rd_word = {16'h0000, map_next[2]};
            `OUTPUT_MAP_A_OFS: rd_word = {16'h0000, map_next[3]};
            `OUTPUT_MAP_B_OFS: rd_word = {16'h0000, map_next[4]};
            `OUTPUT_MAP_C_OFS: rd_word = {16'h0000, map_next[5]};
            `OUTPUT_POLARITY_CTL_OFS: rd_word = {16'h0000, map_next[6]};
            `INPUT_STATE_OFS: rd_word = input_state;
            `OUTPUT_STATE_OFS: rd_word = output_state;
            default: rd_word = 32'h00000000;
        endcase
    end

    // An unmapped or misaligned read still completes as OKAY and returns zero.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h00000000;
        end else if (rd_take) begin
            hrdata_reg <= rd_word;
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Each function reads its own digit; several functions may name one circuit.
    always_comb begin
        in_func_next.fwd_travel_block = pick_input(
            digit_of(map_reg[0], `FWD_TRAVEL_DIGIT), circuit_level, 1'b0, 1'b0);
        in_func_next.rev_travel_block = pick_input(
            digit_of(map_reg[1], `REV_TRAVEL_DIGIT), circuit_level, 1'b0, 1'b0);
        in_func_next.fwd_force_clamp_in = pick_input(
            digit_of(map_reg[1], `FWD_CLAMP_DIGIT), circuit_level, 1'b1, 1'b0);
        in_func_next.rev_force_clamp_in = pick_input(
            digit_of(map_reg[1], `REV_CLAMP_DIGIT), circuit_level, 1'b1, 1'b0);
        in_func_next.option_in_3 = pick_input(
            digit_of(map_reg[2], 2'h0), circuit_level, 1'b1, 1'b0);
        in_func_next.option_in_4 = pick_input(
            digit_of(map_reg[2], 2'h1), circuit_level, 1'b1, 1'b1);
        in_func_next.option_in_5 = pick_input(
            digit_of(map_reg[2], 2'h2), circuit_level, 1'b1, 1'b1);
        in_func_next.option_in_6 = pick_input(
            digit_of(map_reg[2], 2'h3), circuit_level, 1'b1, 1'b1);
    end

    assign out_vec = out_func;

    // Functions sharing a circuit are ORed first, so the polarity bit inverts the combined level.
    always_comb begin
        logic [3:0] code;
        code = 4'h0;
        circuit_next = '0;
        for (int i = 0; i < `OUTPUT_FUNCS; i++) begin
            code = digit_of(map_reg[`OUT_MAP_FIRST + i / 4], 2'(i % 4));
            if (out_used(code)) begin
                circuit_next[out_sel(code)] = circuit_next[out_sel(code)] | out_vec[i];
            end
        end
        circuit_next = circuit_next ^ map_reg[`POLARITY_IDX][`OUTPUT_CIRCUITS-1:0];
    end

    // Inputs and outputs move only on the control tick, so a new allocation acts at the next one.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_func <= '0;
            out_circuit <= '0;
        end else if (ctrl_tick) begin
            in_func <= in_func_next;
            out_circuit <= circuit_next;
        end
    end

    // The alarm is a fail-safe level: it is on only while no error stands, so a lost
    // output also reads as an alarm. It is not held to the control tick.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alarm_out <= 1'b0;
        end else begin
            alarm_out <= !drive_error;
        end
    end

    // Motor current stays blocked unless both safety channels are on.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            base_block <= 1'b1;
        end else begin
            base_block <= !(safety_1 && safety_2);
        end
    end

endmodule : drive_io_signal_allocation

`default_nettype wire

// ### drive_io_alloc_assertions.sv
// Port-level checker of the I/O allocation block, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module alloc_checker #(
    parameter int CTRL_CYCLES = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [31:0] hrdata,
    input wire logic safety_block_in_1,
    input wire logic safety_block_in_2,
    input wire logic drive_error,
    input wire drive_io_pkg::input_func_type in_func,
    input wire logic base_block,
    input wire logic [2:0] out_circuit,
    input wire logic alarm_out
);
    int cnt;
    logic tick;
    // Edge count since release; routed outputs may only move on a control tick.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
    assign tick = (cnt != 0) && (cnt % CTRL_CYCLES == 0);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    a_alarm_error: assert property (drive_error |=> !alarm_out)
        else $error("alarm output on during error");
    a_alarm_clear: assert property (!drive_error [*2] |=> alarm_out)
        else $error("alarm output off without error");
    a_base_open: assert property ((!safety_block_in_1 || !safety_block_in_2) [*4] |-> base_block)
        else $error("current not blocked with a safety channel off");
    a_base_closed: assert property ((safety_block_in_1 && safety_block_in_2) [*5] |-> !base_block)
        else $error("current blocked with both safety channels on");
    a_in_tick: assert property ($changed(in_func) |-> tick)
        else $error("input functions moved off the control tick");
    a_out_tick: assert property ($changed(out_circuit) |-> tick)
        else $error("output circuits moved off the control tick");
    a_reset_clear: assert property ($rose(hresetn) |-> in_func == '0 && out_circuit == 3'h0)
        else $error("routed outputs not cleared by reset");
    a_read_upper: assert property (hrdata[31:17] == 15'h0)
        else $error("unused read data bits set");
    c_out_move: cover property (tick && $changed(out_circuit));
    c_error_gone: cover property (drive_error ##1 !drive_error);
    c_base_lift: cover property (base_block ##1 !base_block);
endmodule : alloc_checker
bind drive_io_signal_allocation alloc_checker #(.CTRL_CYCLES(CTRL_CYCLES)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hrdata(hrdata), .safety_block_in_1(safety_block_in_1),
    .safety_block_in_2(safety_block_in_2), .drive_error(drive_error), .in_func(in_func),
    .base_block(base_block), .out_circuit(out_circuit), .alarm_out(alarm_out));
`default_nettype wire

// ### host_seq_model.sv
// Host controller sequence outputs that feed the drive's input circuits.
`timescale 1ns/1ps
`default_nettype none
module host_seq_model (
    input wire logic hclk,
    input wire logic [6:0] circuit_req,
    input wire logic safety_req,
    input wire logic channel_fault,
    output logic [6:0] circuit_in,
    output logic safety_block_in_1,
    output logic safety_block_in_2
);
    // One request drives both channels; a fault breaks only the second wire.
    initial begin
        circuit_in = 7'h00;
        safety_block_in_1 = 1'b0;
        safety_block_in_2 = 1'b0;
        forever begin
            @(posedge hclk);
            circuit_in <= circuit_req;
            safety_block_in_1 <= safety_req;
            safety_block_in_2 <= safety_req && !channel_fault;
        end
    end
endmodule : host_seq_model
`default_nettype wire

// ### tb.sv
// Self-checking testbench of the I/O allocation block with a reference model.
`timescale 1ns/1ps
`default_nettype none
`include "drive_io_consts.svh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin failures++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, drive_error;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, out_circuit;
    logic [6:0] circuit_in, circuit_req;
    logic safety_1, safety_2, safety_req, channel_fault, base_block, alarm_out;
    drive_io_pkg::output_func_type out_func;
    drive_io_pkg::input_func_type in_func;
    int failures = 0;
    int comparisons = 0;
    int seed = 81;
    int regs [7];
    localparam int SRC [8] = '{3, 4, 6, 7, 8, 9, 10, 11};
    assign hready = hreadyout;
    drive_io_signal_allocation #(.CTRL_CYCLES(2)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .circuit_in(circuit_in),
        .safety_block_in_1(safety_1), .safety_block_in_2(safety_2), .out_func(out_func),
        .drive_error(drive_error), .in_func(in_func), .base_block(base_block),
        .out_circuit(out_circuit), .alarm_out(alarm_out));
    host_seq_model u_host (
        .hclk(hclk), .circuit_req(circuit_req), .safety_req(safety_req),
        .channel_fault(channel_fault), .circuit_in(circuit_in),
        .safety_block_in_1(safety_1), .safety_block_in_2(safety_2));
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    task wrap_up;
        if (failures == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up
    task wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            failures++;
            wrap_up();
        end
    endtask : wait_ready
    task xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        `CHK("hresp", 1'b0, hresp)
    endtask : xfer
    function automatic logic [7:0] exp_in(input logic [6:0] c);
        int code;
        int idx;
        logic v;
        for (int i = 0; i < 8; i++) begin
            code = (regs[SRC[i] / 4] >> (4 * (SRC[i] % 4))) & 15;
            idx = (code > 8) ? code - 9 : code;
            v = (code < 7 || code > 8) ? (c[idx] ^ (code > 8) ^ (i < 2)) : (code == 7);
            if (i > 4 && idx < 4) v = 1'b0;
            exp_in[i] = v;
        end
    endfunction : exp_in
    function automatic logic [2:0] exp_out(input drive_io_pkg::output_func_type f);
        int code;
        exp_out = 3'h0;
        for (int i = 0; i < 9; i++) begin
            code = (regs[3 + i / 4] >> (4 * (i % 4))) & 15;
            if (code >= 1 && code <= 3 && f[i]) exp_out[code - 1] = 1'b1;
        end
        exp_out = exp_out ^ 3'(regs[6]);
    endfunction : exp_out
    task load_regs;
        for (int i = 0; i < 7; i++) begin
            xfer(32'(4 * i), 1'b1, 32'(regs[i]));
            xfer(32'(4 * i), 1'b0, 32'h0);
            `CHK("register", 32'(regs[i]), rd)
        end
    endtask : load_regs
    // Waits past sync stages plus a full control period before judging.
    task check_all;
        logic [31:0] st;
        repeat (8) @(posedge hclk);
        @(negedge hclk);
        `CHK("in_func", exp_in(circuit_req), in_func)
        `CHK("out_circuit", exp_out(out_func), out_circuit)
        `CHK("alarm_out", !drive_error, alarm_out)
        `CHK("base_block", !(safety_req && !channel_fault), base_block)
        st = {15'h0000, safety_req && !channel_fault, safety_req, circuit_req,
            exp_in(circuit_req)};
        xfer(32'h1C, 1'b0, 32'h0);
        `CHK("input_state", st, rd)
        st = {26'h0000000, !(safety_req && !channel_fault), !drive_error, 1'b0,
            exp_out(out_func)};
        xfer(32'h20, 1'b0, 32'h0);
        `CHK("output_state", st, rd)
    endtask : check_all
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        drive_error = 1'b0;
        out_func = '0;
        circuit_req = 7'h00;
        safety_req = 1'b1;
        channel_fault = 1'b0;
        regs = '{`INPUT_MAP_A_RST, `INPUT_MAP_B_RST, `OPTION_INPUT_MAP_RST, `OUTPUT_MAP_A_RST,
            `OUTPUT_MAP_B_RST, `OUTPUT_MAP_C_RST, `OUTPUT_POLARITY_RST};
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            xfer(32'(4 * i), 1'b0, 32'h0);
            `CHK("reset value", 32'(regs[i]), rd)
        end
        xfer(32'h24, 1'b0, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        xfer(32'h02, 1'b1, 32'h0000FFFF);
        xfer(32'h1C, 1'b1, 32'h0000FFFF);
        xfer(32'h00, 1'b0, 32'h0);
        `CHK("misaligned write", 32'(regs[0]), rd)
        check_all();
        // Overtravel digits stay off the inverted codes 9-F: inverting them defeats wire-break safety.
        for (int c = 0; c < 16; c++) begin
            @(posedge hclk);
            regs[0] = (c % 9) << 12;
            regs[1] = (c << 12) | (c << 8) | (c % 9);
            regs[2] = c * 32'h1111;
            circuit_req <= 7'($random(seed));
            load_regs();
            check_all();
        end
        repeat (40) begin
            @(posedge hclk);
            for (int i = 0; i < 6; i++) regs[i] = $random(seed) & 32'hFFFF;
            regs[0][15:12] = 4'(regs[0][15:12] % 9);
            regs[1][3:0] = 4'(regs[1][3:0] % 9);
            regs[6] = $random(seed) & 7;
            if (regs[4][11:8] inside {[1:3]} && regs[6][regs[4][11:8] - 1]) regs[4][11:8] = 4'h0;
            circuit_req <= 7'($random(seed));
            out_func <= 9'($random(seed));
            drive_error <= 1'($random(seed));
            safety_req <= 1'($random(seed));
            channel_fault <= 1'($random(seed));
            load_regs();
            check_all();
        end
        wrap_up();
    end
endmodule : tb
`default_nettype wire
